// ---- inc/adsq_pkg.sv ----
// Constants for the converter sequencer control block
// Assumes a 100 MHz system clock where one state is one clock cycle
package adsq_pkg;
   // Register offsets on the plain register port
   localparam logic [3:0] ADSQ_OFS_CSR = 4'h0;
   localparam logic [3:0] ADSQ_OFS_CR = 4'h1;
   localparam logic [3:0] ADSQ_OFS_RES_A = 4'h2;
   localparam logic [3:0] ADSQ_OFS_RES_B = 4'h3;
   localparam logic [3:0] ADSQ_OFS_RES_C = 4'h4;
   localparam logic [3:0] ADSQ_OFS_RES_D = 4'h5;
   // Control/status field positions
   localparam int ADSQ_CSR_END = 7;
   localparam int ADSQ_CSR_IE = 6;
   localparam int ADSQ_CSR_START = 5;
   localparam int ADSQ_CSR_SCAN = 4;
   localparam int ADSQ_CSR_CTS = 3;
   localparam int ADSQ_CSR_GRP = 2;
   localparam int ADSQ_CR_EXT_TRIGGER_ENABLE = 7;
   localparam logic [7:0] ADSQ_CSR_RESET = 8'h00;
   localparam logic [6:0] ADSQ_CR_RSVD = 7'h7F;
   localparam logic [15:0] ADSQ_RES_RESET = 16'h0000;
   // Timing in states
   localparam int ADSQ_STATE_NS = 10;
   localparam int ADSQ_SYNC_SLOW = 10;
   localparam int ADSQ_SYNC_FAST = 6;
   localparam int ADSQ_SPL_SLOW = 80;
   localparam int ADSQ_SPL_FAST = 40;
   localparam int ADSQ_CONV_SLOW = 256;
   localparam int ADSQ_CONV_FAST = 128;
   localparam int ADSQ_BITS = 10;
   localparam int ADSQ_CNT_W = 9;
   localparam logic [ADSQ_CNT_W-1:0] ADSQ_SYNC_SLOW_C = ADSQ_CNT_W'(ADSQ_SYNC_SLOW);
   localparam logic [ADSQ_CNT_W-1:0] ADSQ_SYNC_FAST_C = ADSQ_CNT_W'(ADSQ_SYNC_FAST);
   localparam logic [ADSQ_CNT_W-1:0] ADSQ_CONV_SLOW_C = ADSQ_CNT_W'(ADSQ_CONV_SLOW);
   localparam logic [ADSQ_CNT_W-1:0] ADSQ_CONV_FAST_C = ADSQ_CNT_W'(ADSQ_CONV_FAST);
   localparam logic [ADSQ_CNT_W-1:0] ADSQ_SPL_SLOW_C = ADSQ_CNT_W'(ADSQ_SPL_SLOW);
   localparam logic [ADSQ_CNT_W-1:0] ADSQ_SPL_FAST_C = ADSQ_CNT_W'(ADSQ_SPL_FAST);

   typedef enum logic [3:0] {
      ADSQ_IDLE = 4'h1,
      ADSQ_SYNC = 4'h2,
      ADSQ_SAMPLE = 4'h4,
      ADSQ_CONVERT = 4'h8
   } adsq_state_e;
endpackage

// ---- inc/adsq_res_if.sv ----
// Result register write and read port between sequencer and result store
// Assumes one clock domain shared by both ends
`timescale 1ns/10ps
`default_nettype none
interface adsq_res_if;
   logic wr_en;
   logic [1:0] wr_idx;
   logic [9:0] wr_data;
   logic [1:0] rd_idx;
   logic [15:0] rd_data;
   modport seq (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
   modport store (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface
`default_nettype wire

// ---- verilog/adsq_result_store.sv ----
// Four 10-bit result registers with 16-bit registered read data
// Assumes synchronous active-low reset on the system clock
`timescale 1ns/10ps
`default_nettype none
module adsq_result_store
   import adsq_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   adsq_res_if.store res
);
   typedef struct packed {
      logic [3:0][9:0] val;
      logic [15:0] rd;
   } adsq_store_s;
   adsq_store_s st_q;
   adsq_store_s st_d;

   always_comb begin
      st_d = st_q;
      if (res.wr_en) begin
         st_d.val[res.wr_idx] = res.wr_data;
      end
      // Top 8 bits high byte, low 2 bits in 7:6, rest zero
      st_d.rd = {st_q.val[res.rd_idx], 6'h00};
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign res.rd_data = st_q.rd;
endmodule
`default_nettype wire

// ---- verilog/adsq_sequencer.sv ----
// Converter sequencer: control/status, trigger, timing, successive approximation
// Assumes register port strobes from CPU logic on CLK and an analog comparator input
//
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
// Operation
// - Ten-bit successive approximation result per conversion
// - Single mode: start bit held, then self-cleared
// - Single end: store, flag, clear start together
// - Flag set with enable raises interrupt
// - Flag clears by read-then-write-zero only
// - Start with new settings in one write
// - Scan begins at group first channel
// - Next scan channel starts immediately
// - Scan cycles until start bit cleared
// - Scan round end: flag, interrupt, restart
// - Restarted scan resumes at first channel
// - Synchronization delay before sampling
// - Sampling interval 80 or 40 states
// - First conversion time from start write
// - Later scan conversions 256 or 128 states
// - Falling trigger edge sets start when enabled
// - Triggered start behaves like software start
// - Channel pairs share one result register
// - Result layout: high byte, bits 7:6
// - Channel select: group, channel or count
// - Scan start bit held until cleared
module adsq_sequencer
   import adsq_pkg::*;
(
   input wire logic CLK,
   input wire logic RESET_N,
   input wire logic STANDBY,
   input wire logic [3:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   output logic CONV_END_IRQ,
   input wire logic EXT_TRIGGER_PIN,
   input wire logic CMP_IN,
   output logic [2:0] ANALOG_SEL,
   output logic SAMPLE_HOLD,
   output logic [9:0] DAC_CODE
);
   typedef struct packed {
      adsq_state_e state;
      logic conv_end_flag;
      logic end_irq_enable;
      logic conv_start_bit;
      logic scan_mode;
      logic conv_time_select;
      logic group_select_bit;
      logic [1:0] channel_select;
      logic ext_trigger_enable;
      logic flag_armed;
      logic [ADSQ_CNT_W-1:0] cnt;
      logic first_conv;
      logic [1:0] chan;
      logic [9:0] sar;
      logic [3:0] bit_idx;
      logic [1:0] trig_sync;
      logic trig_prev;
      logic cmp_s1;
      logic cmp_s2;
      logic [7:0] rdata;
      logic irq;
      logic [2:0] asel;
      logic sh;
      logic [9:0] dac;
      logic rd_hi_pend;
      logic [7:0] temp;
   } adsq_seq_s;

   adsq_seq_s s_q;
   adsq_seq_s s_d;
   adsq_res_if res ();

   adsq_result_store u_store (
      .clk(CLK),
      .reset_n(RESET_N && !STANDBY),
      .res(res)
   );

   // ---------------------------------------------------------------
   // Combinational next state
   // ---------------------------------------------------------------
   logic [ADSQ_CNT_W-1:0] sync_len;
   logic [ADSQ_CNT_W-1:0] spl_len;
   logic [ADSQ_CNT_W-1:0] conv_len;
   logic [ADSQ_CNT_W-1:0] step_len;
   logic [ADSQ_CNT_W-1:0] rem_len;
   logic trig_fall;
   logic wr_csr;
   logic wr_cr;
   logic rd_csr;
   logic set_flag;
   logic conv_done;
   logic last_chan;
   logic [1:0] res_addr_idx;

   always_comb begin
      s_d = s_q;
      res.wr_en = 1'b0;
      res.wr_idx = s_q.scan_mode ? s_q.chan : s_q.channel_select;
      res.wr_data = s_q.sar;
      set_flag = 1'b0;
      conv_done = 1'b0;
      res_addr_idx = ADDR[1:0] - 2'(ADSQ_OFS_RES_A);
      res.rd_idx = res_addr_idx;
      sync_len = s_q.conv_time_select ? ADSQ_SYNC_FAST_C : ADSQ_SYNC_SLOW_C;
      spl_len = s_q.conv_time_select ? ADSQ_SPL_FAST_C : ADSQ_SPL_SLOW_C;
      conv_len = s_q.conv_time_select ? ADSQ_CONV_FAST_C : ADSQ_CONV_SLOW_C;
      // Ten equal bit trials, leftover cycles added to the first trial
      step_len = ADSQ_CNT_W'((conv_len - spl_len) / ADSQ_CNT_W'(ADSQ_BITS));
      rem_len = conv_len - spl_len - ADSQ_CNT_W'(ADSQ_BITS) * step_len;
      wr_csr = WR && (ADDR == ADSQ_OFS_CSR);
      wr_cr = WR && (ADDR == ADSQ_OFS_CR);
      rd_csr = RD && (ADDR == ADSQ_OFS_CSR);
      last_chan = !s_q.scan_mode || (s_q.chan == s_q.channel_select);
      trig_fall = s_q.trig_prev && !s_q.trig_sync[1];

      // Pin synchronisers
      s_d.trig_sync = {s_q.trig_sync[0], EXT_TRIGGER_PIN};
      s_d.trig_prev = s_q.trig_sync[1];
      s_d.cmp_s1 = CMP_IN;
      s_d.cmp_s2 = s_q.cmp_s1;

      // -------------------------------------------------------------
      // Sequencer
      // -------------------------------------------------------------
      case (s_q.state)
         ADSQ_IDLE: begin
            s_d.sh = 1'b0;
         end
         ADSQ_SYNC: begin
            if (s_q.cnt == ADSQ_CNT_W'(1)) begin
               s_d.state = ADSQ_SAMPLE;
               s_d.cnt = spl_len;
               s_d.sh = 1'b1;
            end else begin
               s_d.cnt = s_q.cnt - ADSQ_CNT_W'(1);
            end
         end
         ADSQ_SAMPLE: begin
            if (s_q.cnt == ADSQ_CNT_W'(1)) begin
               s_d.state = ADSQ_CONVERT;
               s_d.sh = 1'b0;
               s_d.bit_idx = 4'h9;
               s_d.sar = 10'h200;
               s_d.dac = 10'h200;
               s_d.cnt = step_len + rem_len;
            end else begin
               s_d.cnt = s_q.cnt - ADSQ_CNT_W'(1);
            end
         end
         ADSQ_CONVERT: begin
            if (s_q.cnt == ADSQ_CNT_W'(1)) begin
               // Comparator high keeps the trial bit
               if (!s_q.cmp_s2) begin
                  s_d.sar[s_q.bit_idx] = 1'b0;
               end
               if (s_q.bit_idx != 4'h0) begin
                  s_d.sar[s_q.bit_idx - 4'h1] = 1'b1;
                  s_d.bit_idx = s_q.bit_idx - 4'h1;
                  s_d.cnt = step_len;
               end else begin
                  conv_done = 1'b1;
               end
               s_d.dac = s_d.sar;
            end else begin
               s_d.cnt = s_q.cnt - ADSQ_CNT_W'(1);
            end
         end
         default: begin
            s_d.state = ADSQ_IDLE;
         end
      endcase

      if (conv_done) begin
         res.wr_en = 1'b1;
         res.wr_data = s_d.sar;
         s_d.first_conv = 1'b0;
         if (last_chan) begin
            set_flag = 1'b1;
         end
         if (!s_q.scan_mode) begin
            s_d.conv_start_bit = 1'b0;
            s_d.state = ADSQ_IDLE;
         end else begin
            // Next channel at once, with the fixed later-conversion time
            s_d.chan = last_chan ? 2'b00 : s_q.chan + 2'b01;
            s_d.state = ADSQ_SAMPLE;
            s_d.cnt = spl_len;
            s_d.sh = 1'b1;
         end
      end

      // -------------------------------------------------------------
      // Register writes
      // -------------------------------------------------------------
      if (wr_csr) begin
         s_d.end_irq_enable = WDATA[ADSQ_CSR_IE];
         s_d.scan_mode = WDATA[ADSQ_CSR_SCAN];
         s_d.conv_time_select = WDATA[ADSQ_CSR_CTS];
         s_d.group_select_bit = WDATA[ADSQ_CSR_GRP];
         s_d.channel_select = WDATA[1:0];
         s_d.conv_start_bit = WDATA[ADSQ_CSR_START];
         if (!WDATA[ADSQ_CSR_END] && s_q.flag_armed) begin
            s_d.conv_end_flag = 1'b0;
            s_d.flag_armed = 1'b0;
         end
      end
      if (wr_cr) begin
         s_d.ext_trigger_enable = WDATA[ADSQ_CR_EXT_TRIGGER_ENABLE];
      end

      // Start from software or pin; a scan always begins at the group's first channel
      if ((wr_csr && WDATA[ADSQ_CSR_START] && !s_q.conv_start_bit)
          || (s_q.ext_trigger_enable && trig_fall && !s_q.conv_start_bit)) begin
         s_d.conv_start_bit = 1'b1;
         s_d.state = ADSQ_SYNC;
         s_d.cnt = sync_len;
         s_d.sh = 1'b0;
         s_d.first_conv = 1'b1;
         s_d.chan = 2'b00;
         if (wr_csr) begin
            sync_len = WDATA[ADSQ_CSR_CTS] ? ADSQ_SYNC_FAST_C : ADSQ_SYNC_SLOW_C;
            s_d.cnt = sync_len;
         end
      end else if (wr_csr && !WDATA[ADSQ_CSR_START]) begin
         s_d.state = ADSQ_IDLE;
         s_d.sh = 1'b0;
      end

      if (rd_csr && s_q.conv_end_flag) begin
         s_d.flag_armed = 1'b1;
      end
      if (set_flag) begin
         s_d.conv_end_flag = 1'b1;
         s_d.flag_armed = 1'b0;
      end
      s_d.irq = s_d.conv_end_flag && s_d.end_irq_enable;

      s_d.asel = {s_d.group_select_bit,
                  s_d.scan_mode ? s_d.chan : s_d.channel_select};

      // Read data, one cycle after the strobe
      s_d.rdata = 8'h00;
      s_d.rd_hi_pend = 1'b0;
      if (RD) begin
         case (ADDR)
            ADSQ_OFS_CSR: s_d.rdata = {s_q.conv_end_flag, s_q.end_irq_enable,
               s_q.conv_start_bit, s_q.scan_mode, s_q.conv_time_select,
               s_q.group_select_bit, s_q.channel_select};
            ADSQ_OFS_CR: s_d.rdata = {s_q.ext_trigger_enable, ADSQ_CR_RSVD};
            ADSQ_OFS_RES_A, ADSQ_OFS_RES_B, ADSQ_OFS_RES_C, ADSQ_OFS_RES_D: begin
               s_d.rd_hi_pend = 1'b1;
            end
            default: s_d.rdata = 8'h00;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (!RESET_N || STANDBY) begin
         s_q <= '0;
         s_q.state <= ADSQ_IDLE;
         s_q.trig_sync <= 2'b11;
         s_q.trig_prev <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // Result reads come from the store's registered data, low byte of word
   assign RDATA = s_q.rd_hi_pend ? res.rd_data[7:0] : s_q.rdata;
   assign CONV_END_IRQ = s_q.irq;
   assign ANALOG_SEL = s_q.asel;
   assign SAMPLE_HOLD = s_q.sh;
   assign DAC_CODE = s_q.dac;
endmodule
`default_nettype wire

// ---- bench/adsq_seq_asserts.sv ----
// Port checker for the converter sequencer
// Assumes binding onto adsq_sequencer, one clock domain
`timescale 1ns/10ps
`default_nettype none
module adsq_seq_asserts
   import adsq_pkg::*;
(
   input wire logic CLK,
   input wire logic RESET_N,
   input wire logic STANDBY,
   input wire logic [3:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [7:0] RDATA,
   input wire logic CONV_END_IRQ,
   input wire logic EXT_TRIGGER_PIN,
   input wire logic CMP_IN,
   input wire logic [2:0] ANALOG_SEL,
   input wire logic SAMPLE_HOLD,
   input wire logic [9:0] DAC_CODE
);
   // ----------------------------------------
   // Shadow of written settings, read arming and sampling length
   // ----------------------------------------
   logic cts_q, ie_q, grp_q, armed_q;
   logic [6:0] spl_q;
   wire logic csr_wr = WR && ADDR == ADSQ_OFS_CSR;
   always_ff @(posedge CLK) begin
      if (!RESET_N || STANDBY) begin
         cts_q <= 1'b0;
         ie_q <= 1'b0;
         grp_q <= 1'b0;
         armed_q <= 1'b0;
         spl_q <= 7'h00;
      end else begin
         if (csr_wr) begin
            cts_q <= WDATA[ADSQ_CSR_CTS];
            ie_q <= WDATA[ADSQ_CSR_IE];
            grp_q <= WDATA[ADSQ_CSR_GRP];
         end
         armed_q <= CONV_END_IRQ && (armed_q || (RD && ADDR == ADSQ_OFS_CSR));
         spl_q <= SAMPLE_HOLD ? spl_q + 7'h01 : 7'h00;
      end
   end
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESET_N || STANDBY);
   a_sample_len: assert property (
      (SAMPLE_HOLD && !csr_wr) ##1 !SAMPLE_HOLD |-> spl_q == (cts_q ? 7'h28 : 7'h50))
      else $error("sampling interval length wrong");
   a_sync_delay: assert property (
      csr_wr && WDATA[ADSQ_CSR_START] && !WDATA[ADSQ_CSR_SCAN] && !SAMPLE_HOLD
      |=> !SAMPLE_HOLD [*4] ##[1:14] SAMPLE_HOLD)
      else $error("sampling not begun after start delay");
   a_sar_start: assert property (
      $fell(SAMPLE_HOLD) && !$past(csr_wr) |-> ##[0:3] DAC_CODE == 10'h200)
      else $error("first trial code not mid scale");
   a_irq_enable: assert property (
      !ie_q |-> !CONV_END_IRQ)
      else $error("interrupt while disabled");
   a_irq_holds: assert property (
      CONV_END_IRQ && !csr_wr && !$past(csr_wr) |=> CONV_END_IRQ)
      else $error("interrupt dropped without a write");
   a_clear_read: assert property (
      $fell(CONV_END_IRQ) && ie_q |-> $past(armed_q))
      else $error("flag cleared without prior read");
   a_result_low: assert property (
      RD && ADDR >= ADSQ_OFS_RES_A && ADDR <= ADSQ_OFS_RES_D |=> RDATA[5:0] == 6'h00)
      else $error("result low bits not zero");
   a_sel_group: assert property (
      SAMPLE_HOLD |-> ANALOG_SEL[2] == grp_q)
      else $error("sampled input outside group");
   cover property ($rose(CONV_END_IRQ));
   cover property (csr_wr && WDATA[ADSQ_CSR_SCAN] && WDATA[ADSQ_CSR_START]);
   cover property ($fell(EXT_TRIGGER_PIN) ##[1:20] SAMPLE_HOLD);
endmodule
bind adsq_sequencer adsq_seq_asserts u_chk (.CLK(CLK), .RESET_N(RESET_N),
   .STANDBY(STANDBY), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
   .CONV_END_IRQ(CONV_END_IRQ), .EXT_TRIGGER_PIN(EXT_TRIGGER_PIN), .CMP_IN(CMP_IN),
   .ANALOG_SEL(ANALOG_SEL), .SAMPLE_HOLD(SAMPLE_HOLD), .DAC_CODE(DAC_CODE));
`default_nettype wire

// ---- bench/adsq_analog_model.sv ----
// Analog inputs with sample-and-hold and comparator
// Assumes levels packed ten bits per input, input 0 lowest
`timescale 1ns/10ps
`default_nettype none
module adsq_analog_model (
   input wire logic clk,
   input wire logic [2:0] sel,
   input wire logic hold,
   input wire logic [9:0] code,
   input wire logic [79:0] levels,
   output logic cmp
);
   // ----------------------------------------
   // Held level compared with trial code
   // ----------------------------------------
   logic [9:0] held_q = 10'h000;
   always @(posedge clk) begin
      if (hold) begin
         held_q <= levels[sel*10 +: 10];
      end
   end
   assign cmp = held_q >= code;
endmodule
`default_nettype wire

// ---- bench/test_adc_sequencer_control.sv ----
// Self-checking bench for the converter sequencer
// Assumes adsq_sequencer top and the analog model beside it
`timescale 1ns/10ps
`default_nettype none
module test_adc_sequencer_control
   import adsq_pkg::*;
;
   // ----------------------------------------
   // Stimulus, model and checks
   // ----------------------------------------
   logic clk, reset_n, standby, we, re, trig, irq, sh, cmp;
   logic [3:0] addr;
   logic [7:0] wdata, rdata, d;
   logic [2:0] sel;
   logic [9:0] code;
   logic [79:0] levels;
   logic [31:0] seed = 32'h00000015;
   logic [31:0] v;
   int miscompares, num_checks, cyc, t0, t1, i, n, k;
   int res_m[4];
   adsq_sequencer DUT (.CLK(clk), .RESET_N(reset_n), .STANDBY(standby), .ADDR(addr),
      .WDATA(wdata), .WR(we), .RD(re), .RDATA(rdata), .CONV_END_IRQ(irq),
      .EXT_TRIGGER_PIN(trig), .CMP_IN(cmp), .ANALOG_SEL(sel), .SAMPLE_HOLD(sh),
      .DAC_CODE(code));
   adsq_analog_model u_ana (.clk(clk), .sel(sel), .hold(sh), .code(code),
      .levels(levels), .cmp(cmp));
   function logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task tick();
      @(posedge clk);
      #1;
   endtask
   task wr(input logic [3:0] a, input logic [7:0] x);
      addr <= a;
      wdata <= x;
      we <= 1'b1;
      tick();
      we <= 1'b0;
      tick();
   endtask
   task rd(input logic [3:0] a);
      addr <= a;
      re <= 1'b1;
      tick();
      re <= 1'b0;
      d = rdata;
      tick();
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         miscompares++;
         $display("mismatch at %0t: got %h want %h", $time, s, e);
      end
   endtask
   task wait_on(input logic v0, input logic is_sh);
      k = 0;
      while ((is_sh ? sh : irq) !== v0 && k < 1000) begin
         tick();
         k++;
      end
      if (k >= 1000) begin
         miscompares++;
         $display("mismatch at %0t: wait timed out", $time);
      end
   endtask
   task set_lvl(input int ch, input int slot);
      v = xs();
      levels[ch*10 +: 10] <= v[9:0];
      res_m[slot] = v[9:0];
   endtask
   task print_verdict();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         miscompares++;
         print_verdict();
      end
   end
   initial begin
      {reset_n, standby, we, re, addr, wdata, levels} = '0;
      trig = 1'b1;
      repeat (6) @(posedge clk);
      #1;
      reset_n <= 1'b1;
      tick();
      rd(ADSQ_OFS_CSR);
      chk(d, ADSQ_CSR_RESET);
      rd(ADSQ_OFS_CR);
      chk(d, {1'b0, ADSQ_CR_RSVD});
      rd(4'hF);
      chk(d, 8'h00);
      for (i = 0; i < 8; i++) begin
         set_lvl(i, i % 4);
         tick();
         wr(ADSQ_OFS_CSR, {4'h6, i[0], i[2:0]});
         t0 = cyc - 1;
         repeat (40) tick();
         rd(ADSQ_OFS_CSR);
         chk(d[ADSQ_CSR_START], 1'b1);
         wait_on(1'b1, 1'b0);
         n = cyc - t0;
         chk(n >= (i[0] ? 131 : 259) && n <= (i[0] ? 134 : 266), 1);
         chk(code, res_m[i % 4]);
         wr(ADSQ_OFS_CSR, 8'h40);
         tick();
         chk(irq, 1'b1);
         rd(ADSQ_OFS_CSR);
         chk(d, 8'hC0);
         wr(ADSQ_OFS_CSR, 8'h40);
         tick();
         chk(irq, 1'b0);
         rd(ADSQ_OFS_RES_A + i[1:0]);
         chk(d, {res_m[i % 4][1:0], 6'h00});
      end
      for (i = 4; i < 7; i++) begin
         set_lvl(i, i - 4);
         tick();
      end
      wr(ADSQ_OFS_CSR, 8'h76);
      wait_on(1'b1, 1'b1);
      chk(sel, 3'h4);
      wait_on(1'b1, 1'b0);
      t1 = cyc;
      rd(ADSQ_OFS_CSR);
      chk(d[ADSQ_CSR_START], 1'b1);
      wr(ADSQ_OFS_CSR, 8'h76);
      wait_on(1'b1, 1'b0);
      n = cyc - t1;
      repeat (200) tick();
      wr(ADSQ_OFS_CSR, 8'h56);
      chk(n, 3 * ADSQ_CONV_SLOW);
      for (i = 0; i < 3; i++) begin
         rd(ADSQ_OFS_RES_A + i[1:0]);
         chk(d, {res_m[i][1:0], 6'h00});
      end
      repeat (20) tick();
      wr(ADSQ_OFS_CSR, 8'h76);
      wait_on(1'b1, 1'b1);
      chk(sel, 3'h4);
      standby <= 1'b1;
      repeat (2) tick();
      standby <= 1'b0;
      tick();
      rd(ADSQ_OFS_CSR);
      chk(d, ADSQ_CSR_RESET);
      set_lvl(2, 2);
      wr(ADSQ_OFS_CR, 8'h80);
      wr(ADSQ_OFS_CSR, 8'h42);
      trig <= 1'b0;
      wait_on(1'b1, 1'b0);
      chk(irq, 1'b1);
      rd(ADSQ_OFS_RES_C);
      chk(d, {res_m[2][1:0], 6'h00});
      wr(ADSQ_OFS_CSR, 8'h02);
      tick();
      chk(irq, 1'b0);
      rd(ADSQ_OFS_CSR);
      chk(d, 8'h82);
      wr(ADSQ_OFS_CSR, 8'h40);
      trig <= 1'b1;
      wr(ADSQ_OFS_CR, 8'h00);
      trig <= 1'b0;
      repeat (300) tick();
      rd(ADSQ_OFS_CSR);
      chk(d, 8'h40);
      print_verdict();
   end
endmodule
`default_nettype wire
